// >>> core/ddac_defs.vh
// Constants for the dual DAC serial command block
// Overview of operation
// - Frame is 24 bits MSB first: command, address (B,0,0,A), then data.
// - Shift on falling serial clock while frame select low; act on its rise.
// - Command 1000 writes chain enable from DB0; standalone after reset.
// - Each clock shifts the register; overflow bits go to serial output.
// - Serial output changes on rising serial clock edge.
// - Frame with clock count not multiple of 24 still executes.
// - Frame select rise latches frame; later clocks ignored until next frame.
// - Command 1001 arms readback of addressed DAC register; data ignored.
// - Serial output enabled for readback even in standalone mode.
// - Readback with zero or two channel bits returns channel A.
// - Next frame shifts out four undefined bits then DAC register as DB19-DB10.
// - Command 0100 sets power modes: DB7-6 channel B, DB1-0 channel A.
// - Power field: 00 normal, 01 1k, 10 100k, 11 high impedance.
// - Power-down keeps DAC register and still allows updates.
// - Output valid about 4.5 us after return to normal operation.
// - Each channel has input and DAC registers; load strobe governs transfer.
// - Command 0001 with load strobe low updates input and DAC registers.
// - Strobe high: DAC registers load on later falling load strobe edge.
// - Masked channel ignores load strobe; command 0101 DB3 B, DB0 A.
`ifndef DDAC_DEFS_VH
`define DDAC_DEFS_VH
`define DDAC_FRAME_BITS     24
`define DDAC_CMD_NOP        4'h0
`define DDAC_CMD_WR_IN      4'h1
`define DDAC_CMD_UPD_DAC    4'h2
`define DDAC_CMD_WR_UPD     4'h3
`define DDAC_CMD_POWER      4'h4
`define DDAC_CMD_MASK       4'h5
`define DDAC_CMD_SWRESET    4'h6
`define DDAC_CMD_CHAIN      4'h8
`define DDAC_CMD_READBACK   4'h9
`define DDAC_ADDR_B_BIT     19
`define DDAC_ADDR_A_BIT     16
`define DDAC_DATA_MSB       15
`define DDAC_DATA_LSB       6
`define DDAC_PWR_B_HI       7
`define DDAC_PWR_A_HI       1
`define DDAC_MASK_B_BIT     3
`define DDAC_MASK_A_BIT     0
`define DDAC_CHAIN_BIT      0
`define DDAC_CHAIN_RST      1'b0
`define DDAC_PWR_NORMAL     2'h0
`define DDAC_PWR_1K         2'h1
`define DDAC_PWR_100K       2'h2
`define DDAC_PWR_HIZ        2'h3
`define DDAC_WAKE_NS        4500
`define DDAC_CLK_NS         5
`define DDAC_WAKE_CYC       ((`DDAC_WAKE_NS + `DDAC_CLK_NS - 1) / `DDAC_CLK_NS)
`endif

// >>> core/ddac_serial_core.v
// Serial command logic of a dual 10-bit DAC
`timescale 1ns/1ps
`include "ddac_defs.vh"
module ddac_serial_core #(
    parameter integer DATA_W   = 10,
    parameter integer WAKE_CYC = `DDAC_WAKE_CYC
) (
    input  wire              i_ref_clk,
    input  wire              i_rst_n,
    input  wire              i_frame_select_n,
    input  wire              i_serial_clk,
    input  wire              i_serial_data_in,
    input  wire              i_load_strobe_n,
    output reg               o_serial_data_out,
    output reg               o_serial_data_out_oe,
    output reg  [DATA_W-1:0] o_dac_a,
    output reg  [DATA_W-1:0] o_dac_b,
    output reg  [DATA_W-1:0] o_input_a,
    output reg  [DATA_W-1:0] o_input_b,
    output reg  [1:0]        o_chan_a_power,
    output reg  [1:0]        o_chan_b_power,
    output reg               o_chan_a_valid,
    output reg               o_chan_b_valid,
    output reg               o_chain_enable_bit,
    output reg  [1:0]        o_load_mask
);
    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    reg [1:0] sel_sync_ff;
    reg [1:0] sclk_sync_ff;
    reg [1:0] serial_data_in_sync_ff;
    reg [1:0] load_strobe_n_sync_ff;
    reg       sel_d_ff;
    reg       sclk_d_ff;
    reg       load_strobe_n_d_ff;
    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            sel_sync_ff  <= 2'h3;
            sclk_sync_ff <= 2'h3;
            serial_data_in_sync_ff <= 2'h0;
            load_strobe_n_sync_ff <= 2'h3;
            sel_d_ff     <= 1'b1;
            sclk_d_ff    <= 1'b1;
            load_strobe_n_d_ff    <= 1'b1;
        end else begin
            sel_sync_ff  <= {sel_sync_ff[0], i_frame_select_n};
            sclk_sync_ff <= {sclk_sync_ff[0], i_serial_clk};
            serial_data_in_sync_ff <= {serial_data_in_sync_ff[0], i_serial_data_in};
            load_strobe_n_sync_ff <= {load_strobe_n_sync_ff[0], i_load_strobe_n};
            sel_d_ff     <= sel_sync_ff[1];
            sclk_d_ff    <= sclk_sync_ff[1];
            load_strobe_n_d_ff    <= load_strobe_n_sync_ff[1];
        end
    end
    wire sel_n     = sel_sync_ff[1];
    wire serial_data_in      = serial_data_in_sync_ff[1];
    wire load_strobe_n_n    = load_strobe_n_sync_ff[1];
    wire frame_end = sel_n & ~sel_d_ff;
    wire sclk_fall = ~sclk_sync_ff[1] & sclk_d_ff & ~sel_n;
    wire sclk_rise = sclk_sync_ff[1] & ~sclk_d_ff & ~sel_n;
    wire load_strobe_n_fall = ~load_strobe_n_n & load_strobe_n_d_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Shift register and frame decode
    reg  [23:0] shift_ff;
    reg  [23:0] nxt_shift;
    reg         rb_armed_ff;
    reg         rb_active_ff;
    reg         rb_sel_b_ff;
    reg         out_bit_ff;
    wire [3:0]  cmd    = shift_ff[23:20];
    wire        addr_b = shift_ff[`DDAC_ADDR_B_BIT];
    wire        addr_a = shift_ff[`DDAC_ADDR_A_BIT];
    wire [DATA_W-1:0] data_w = shift_ff[`DDAC_DATA_MSB:`DDAC_DATA_LSB];
    wire        frame_start = ~sel_n & sel_d_ff;
    wire [DATA_W-1:0] rb_word = rb_sel_b_ff ? o_dac_b : o_dac_a;
    always @* begin
        nxt_shift = shift_ff;
        if (frame_start && rb_armed_ff) begin
            // Readback image: four undefined bits, then DAC register at DB19-DB10
            nxt_shift        = 24'h000000;
            nxt_shift[19:10] = rb_word;
        end else if (sclk_fall) begin
            nxt_shift = {shift_ff[22:0], serial_data_in};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame execution and register bank
    reg load_strobe_n_low_frame_ff;
    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            shift_ff           <= 24'h000000;
            out_bit_ff         <= 1'b0;
            rb_armed_ff        <= 1'b0;
            rb_active_ff       <= 1'b0;
            rb_sel_b_ff        <= 1'b0;
            load_strobe_n_low_frame_ff  <= 1'b0;
            o_chain_enable_bit <= `DDAC_CHAIN_RST;
            o_chan_a_power     <= `DDAC_PWR_NORMAL;
            o_chan_b_power     <= `DDAC_PWR_NORMAL;
            o_load_mask        <= 2'h0;
            o_input_a          <= {DATA_W{1'b0}};
            o_input_b          <= {DATA_W{1'b0}};
            o_dac_a            <= {DATA_W{1'b0}};
            o_dac_b            <= {DATA_W{1'b0}};
        end else begin
            shift_ff <= nxt_shift;
            if (sclk_rise) begin
                out_bit_ff <= shift_ff[23];
            end
            if (frame_start) begin
                rb_active_ff      <= rb_armed_ff;
                rb_armed_ff       <= 1'b0;
                load_strobe_n_low_frame_ff <= 1'b0;
            end else if (~sel_n && !load_strobe_n_n) begin
                load_strobe_n_low_frame_ff <= 1'b1;
            end
            // Deferred transfer on the strobe edge, masked channels excluded
            if (load_strobe_n_fall && sel_n) begin
                if (!o_load_mask[0]) o_dac_a <= o_input_a;
                if (!o_load_mask[1]) o_dac_b <= o_input_b;
            end
            if (frame_end) begin
                rb_active_ff <= 1'b0;
                case (cmd)
                    `DDAC_CMD_WR_IN: begin
                        if (addr_a) o_input_a <= data_w;
                        if (addr_b) o_input_b <= data_w;
                        if (addr_a && (load_strobe_n_low_frame_ff || !load_strobe_n_n) && !o_load_mask[0])
                            o_dac_a <= data_w;
                        if (addr_b && (load_strobe_n_low_frame_ff || !load_strobe_n_n) && !o_load_mask[1])
                            o_dac_b <= data_w;
                    end
                    `DDAC_CMD_UPD_DAC: begin
                        if (addr_a) o_dac_a <= o_input_a;
                        if (addr_b) o_dac_b <= o_input_b;
                    end
                    `DDAC_CMD_WR_UPD: begin
                        if (addr_a) begin
                            o_input_a <= data_w;
                            o_dac_a   <= data_w;
                        end
                        if (addr_b) begin
                            o_input_b <= data_w;
                            o_dac_b   <= data_w;
                        end
                    end
                    `DDAC_CMD_POWER: begin
                        o_chan_b_power <= shift_ff[`DDAC_PWR_B_HI -: 2];
                        o_chan_a_power <= shift_ff[`DDAC_PWR_A_HI -: 2];
                    end
                    `DDAC_CMD_MASK: begin
                        o_load_mask <= {shift_ff[`DDAC_MASK_B_BIT], shift_ff[`DDAC_MASK_A_BIT]};
                    end
                    `DDAC_CMD_SWRESET: begin
                        o_chain_enable_bit <= `DDAC_CHAIN_RST;
                        o_chan_a_power     <= `DDAC_PWR_NORMAL;
                        o_chan_b_power     <= `DDAC_PWR_NORMAL;
                        o_load_mask        <= 2'h0;
                        o_input_a          <= {DATA_W{1'b0}};
                        o_input_b          <= {DATA_W{1'b0}};
                        o_dac_a            <= {DATA_W{1'b0}};
                        o_dac_b            <= {DATA_W{1'b0}};
                    end
                    `DDAC_CMD_CHAIN: begin
                        o_chain_enable_bit <= shift_ff[`DDAC_CHAIN_BIT];
                    end
                    `DDAC_CMD_READBACK: begin
                        rb_armed_ff <= 1'b1;
                        rb_sel_b_ff <= addr_b & ~addr_a;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial output driver
    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_serial_data_out    <= 1'b0;
            o_serial_data_out_oe <= 1'b0;
        end else begin
            o_serial_data_out    <= out_bit_ff;
            o_serial_data_out_oe <= ~sel_n & (o_chain_enable_bit | rb_active_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power-up settling per channel
    reg [12:0] wake_a_ff;
    reg [12:0] wake_b_ff;
    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            wake_a_ff      <= 13'h0000;
            wake_b_ff      <= 13'h0000;
            o_chan_a_valid <= 1'b1;
            o_chan_b_valid <= 1'b1;
        end else begin
            if (o_chan_a_power != `DDAC_PWR_NORMAL) begin
                wake_a_ff      <= WAKE_CYC[12:0];
                o_chan_a_valid <= 1'b0;
            end else if (wake_a_ff != 13'h0000) begin
                wake_a_ff      <= wake_a_ff - 13'h0001;
                o_chan_a_valid <= (wake_a_ff == 13'h0001);
            end
            if (o_chan_b_power != `DDAC_PWR_NORMAL) begin
                wake_b_ff      <= WAKE_CYC[12:0];
                o_chan_b_valid <= 1'b0;
            end else if (wake_b_ff != 13'h0000) begin
                wake_b_ff      <= wake_b_ff - 13'h0001;
                o_chan_b_valid <= (wake_b_ff == 13'h0001);
            end
        end
    end
endmodule // ddac_serial_core

// >>> verification/ddac_serial_core_asserts.sv
// Concurrent checks on the ports of the dual DAC serial command block
`timescale 1ns/1ps
module ddac_serial_core_asserts (
    input wire logic       i_ref_clk,
    input wire logic       i_rst_n,
    input wire logic       i_frame_select_n,
    input wire logic       i_serial_clk,
    input wire logic       i_load_strobe_n,
    input wire logic       o_serial_data_out,
    input wire logic       o_serial_data_out_oe,
    input wire logic [9:0] o_dac_a,
    input wire logic [9:0] o_dac_b,
    input wire logic [9:0] o_input_a,
    input wire logic [9:0] o_input_b,
    input wire logic [1:0] o_chan_a_power,
    input wire logic [1:0] o_chan_b_power,
    input wire logic       o_chan_a_valid,
    input wire logic       o_chan_b_valid,
    input wire logic       o_chain_enable_bit,
    input wire logic [1:0] o_load_mask
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    chk_reset_defaults: assert property ($rose(i_rst_n) |-> !o_chain_enable_bit
        && !o_serial_data_out_oe && o_chan_a_valid && o_dac_a == 10'h000)
        else $error("bad state after reset");
    chk_pwr_keeps_dac: assert property ($changed(o_chan_a_power) |-> $stable(o_dac_a))
        else $error("power change altered the DAC register");
    chk_valid_low_pd: assert property (o_chan_b_power != 2'h0 |=> !o_chan_b_valid)
        else $error("valid high during power-down");
    chk_wake_delay: assert property ($past(o_chan_a_power) != 2'h0 && o_chan_a_power == 2'h0
        |-> !o_chan_a_valid [*8] ##[1:12] o_chan_a_valid) else $error("wake delay wrong");
    chk_oe_standalone: assert property ((!o_chain_enable_bit && i_frame_select_n) [*8]
        |-> !o_serial_data_out_oe) else $error("serial output driven when idle");
    chk_input_quiet: assert property ($changed(o_input_a) |-> i_frame_select_n)
        else $error("input register changed inside a frame");
    chk_dac_from_input: assert property ($changed(o_dac_b) |-> o_dac_b == o_input_b)
        else $error("DAC register not taken from input register");
    chk_mask_blocks: assert property (o_load_mask[0] && $fell(i_load_strobe_n)
        |-> $stable(o_dac_a) [*6]) else $error("masked channel followed the strobe");
    chk_sdo_on_rise: assert property ($changed(o_serial_data_out) |-> i_serial_clk)
        else $error("serial output moved in the low clock phase");
    cover property ($rose(o_chain_enable_bit));
    cover property ($rose(o_serial_data_out_oe));
    cover property ($fell(i_load_strobe_n) && i_frame_select_n);
endmodule // ddac_serial_core_asserts

// >>> verification/ddac_spi_host.sv
// Serial host model driving frames and collecting the serial output
`timescale 1ns/1ps
module ddac_spi_host (
    input  wire logic i_ref_clk,
    input  wire logic i_serial_data_out,
    input  wire logic i_serial_data_out_oe,
    output logic      o_frame_select_n = 1'b1,
    output logic      o_serial_clk = 1'b1,
    output logic      o_serial_data_in = 1'b0
);
    // Clock parks high between frames; each bit takes 25 cycles, 125 ns
    task automatic xfer(input logic [47:0] w, input int n, output logic [47:0] rx,
                        output logic oe_seen);
        rx = '0;
        oe_seen = 1'b0;
        @(negedge i_ref_clk) o_frame_select_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            @(negedge i_ref_clk) o_serial_data_in = w[i];
            repeat (12) @(negedge i_ref_clk);
            rx[i] = i_serial_data_out;
            oe_seen |= i_serial_data_out_oe;
            o_serial_clk = 1'b0;
            repeat (12) @(negedge i_ref_clk);
            o_serial_clk = 1'b1;
        end
        repeat (12) @(negedge i_ref_clk);
        o_serial_data_in = ~o_serial_data_in;
        o_frame_select_n = 1'b1;
    endtask
endmodule // ddac_spi_host

// >>> verification/ddac_serial_core_tb_top.sv
// Self-checking testbench of the dual DAC serial command block
`timescale 1ns/1ps
module ddac_serial_core_tb_top;
    logic        clk = 1'b0, rst_n = 1'b0, load_strobe_n_n = 1'b1, oe_seen;
    logic [47:0] rx;
    wire         fs_n, sclk, sdi, serial_data_out, oe, chain, va, vb;
    wire  [9:0]  dac_a, dac_b, in_a, in_b;
    wire  [1:0]  pa, pb, mask;
    int          miscompares = 0, n_checks = 0;
    logic [3:0]  adr [4] = '{4'h1, 4'h8, 4'h9, 4'h0};
    logic [9:0]  rb [4] = '{10'h2A5, 10'h3C3, 10'h2A5, 10'h2A5};
    initial forever #2.5 clk = ~clk;
    ddac_spi_host host (.i_ref_clk(clk), .i_serial_data_out(serial_data_out), .i_serial_data_out_oe(oe),
        .o_frame_select_n(fs_n), .o_serial_clk(sclk), .o_serial_data_in(sdi));
    ddac_serial_core #(.WAKE_CYC(10)) dut (.i_ref_clk(clk), .i_rst_n(rst_n),
        .i_frame_select_n(fs_n), .i_serial_clk(sclk), .i_serial_data_in(sdi),
        .i_load_strobe_n(load_strobe_n_n), .o_serial_data_out(serial_data_out), .o_serial_data_out_oe(oe),
        .o_dac_a(dac_a), .o_dac_b(dac_b), .o_input_a(in_a), .o_input_b(in_b),
        .o_chan_a_power(pa), .o_chan_b_power(pb), .o_chan_a_valid(va), .o_chan_b_valid(vb),
        .o_chain_enable_bit(chain), .o_load_mask(mask));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic frame(input logic [47:0] w, input int n = 24);
        host.xfer(w, n, rx, oe_seen);
        repeat (20) @(negedge clk);
    endtask
    task automatic pulse();
        @(negedge clk) load_strobe_n_n = 1'b0;
        repeat (10) @(negedge clk);
        load_strobe_n_n = 1'b1;
        repeat (10) @(negedge clk);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        final_report();
    end
    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        chk("reset", 32'h3000_0000, {2'b0, va, vb, chain, oe, mask, pa, pb, dac_a, dac_b});
        $display("test reset done");
        load_strobe_n_n = 1'b0;
        frame({4'h1, 4'h1, 10'h2A5, 6'h0});
        load_strobe_n_n = 1'b1;
        chk("load_now", {10'h2A5, 10'h2A5}, {in_a, dac_a});
        frame({4'h1, 4'h8, 10'h155, 6'h0});
        chk("load_held", {10'h155, 10'h000}, {in_b, dac_b});
        pulse();
        chk("load_strobe", 10'h155, dac_b);
        frame({4'h5, 20'h00001});
        chk("mask", 2'b01, mask);
        frame({4'h1, 4'h1, 10'h0F0, 6'h0});
        pulse();
        chk("masked", {10'h0F0, 10'h2A5}, {in_a, dac_a});
        $display("test load done");
        for (int m = 1; m <= 4; m++) begin
            frame({4'h4, 12'h000, m[1:0], 4'hF, m[1:0]});
            chk("power", {m[1:0], m[1:0]}, {pb, pa});
            chk("valid", {2{m == 4}}, {va, vb});
            if (m == 2) begin
                load_strobe_n_n = 1'b0;
                frame({4'h1, 4'h8, 10'h3C3, 6'h0});
                load_strobe_n_n = 1'b1;
                chk("pd_update", {10'h2A5, 10'h3C3}, {dac_a, dac_b});
            end
        end
        $display("test power done");
        for (int k = 0; k < 4; k++) begin
            frame({4'h9, adr[k], 16'hFFFF});
            frame(48'h0);
            chk("readback", rb[k], rx[19:10]);
            chk("rb_oe", 1'b1, oe_seen);
            chk("oe_after", 1'b0, oe);
        end
        $display("test readback done");
        frame({4'h3, 4'h1, 10'h1E1, 6'h0});
        chk("wr_upd", {10'h1E1, 10'h1E1}, {in_a, dac_a});
        frame({4'h1, 4'h8, 10'h0AA, 6'h0});
        frame({4'h2, 4'h8, 16'h0000});
        chk("upd_dac", {10'h0AA, 10'h0AA}, {in_b, dac_b});
        frame({4'h6, 20'h00000});
        chk("sw_reset", 32'h0000_0000, {mask, dac_a, dac_b});
        $display("test update done");
        frame({4'h8, 20'h00001});
        chk("chain_on", 1'b1, chain);
        frame({24'h3C5A69, 24'hF00000}, 48);
        chk("chain_out", 24'h3C5A69, rx[23:0]);
        frame({18'h0, 6'h2A, 24'h800000}, 30);
        chk("odd_count", 1'b0, chain);
        frame(48'h0);
        chk("standalone_oe", 1'b0, oe_seen);
        $display("test chain done");
        final_report();
    end
endmodule // ddac_serial_core_tb_top
bind ddac_serial_core ddac_serial_core_asserts chk_i (.i_ref_clk, .i_rst_n, .i_frame_select_n,
    .i_serial_clk, .i_load_strobe_n, .o_serial_data_out, .o_serial_data_out_oe, .o_dac_a,
    .o_dac_b, .o_input_a, .o_input_b, .o_chan_a_power, .o_chan_b_power, .o_chan_a_valid,
    .o_chan_b_valid, .o_chain_enable_bit, .o_load_mask);
